// *** dcc_defs.svh ***
// Bit positions, reset values and fixed counts of the debug configuration low half
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

`define DCC_BIT_TRC        14
`define DCC_BIT_DDC_HI     12
`define DCC_BIT_DDC_LO     11
`define DCC_BIT_UHE        10
`define DCC_BIT_BTB_HI     9
`define DCC_BIT_BTB_LO     8
`define DCC_BIT_NPL        6
`define DCC_BIT_IPI        5
`define DCC_BIT_SSM        4
`define DCC_BIT_FID        1
`define DCC_BIT_DDH        0
`define DCC_WMASK          32'h0000_5F73
`define DCC_RESET          32'h0000_0000
`define DCC_BYTE_NIBBLES   4'h2
`define DCC_WORD_NIBBLES   4'h4
`define DCC_LONG_NIBBLES   4'h8
`define DCC_BTB2_NIBBLES   4'h4
`define DCC_BTB3_NIBBLES   4'h6
`define DCC_MARK_BYTE      4'h8
`define DCC_MARK_WORD      4'h9
`define DCC_MARK_LONG      4'hB
`define DCC_MARK_BTB2      4'hA
`define DCC_MARK_BTB3      4'hC

`endif

// *** dcc_pkg.sv ***
// Types shared by the debug configuration control block
package dcc_pkg;
    typedef enum logic [1:0] {DCC_SZ_BYTE, DCC_SZ_WORD, DCC_SZ_LONG} dcc_size_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  mark;
        logic [3:0]  nibbles;
    } dcc_trace_t;

    typedef struct packed {
        logic        valid;
        logic        is_write;
        dcc_size_t   size;
        logic [31:0] data;
    } dcc_operand_t;
endpackage

// *** dcc_buf2.sv ***
// Two-entry valid/ready buffer for trace words
`timescale 1ns/1ps
`default_nettype none
module dcc_buf2
    import dcc_pkg::*;
(
    input  wire logic       mclk,      // System clock
    input  wire logic       rst_n,     // Async reset, active low
    input  wire dcc_trace_t in_data,   // Word from producer
    input  wire logic       in_valid,  // Producer has a word
    output var  logic       in_ready,  // Room for a word
    output var  dcc_trace_t out_data,  // Oldest word
    output var  logic       out_valid, // Oldest word present
    input  wire logic       out_ready  // Consumer takes word
);
    dcc_trace_t     mem_ff [2];
    logic           wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [1:0]     cnt_ff, nxt_cnt;
    logic           push, pop;
    logic           rdy_ff, nxt_rdy;

    assign push      = in_valid && (cnt_ff != 2'd2);
    assign pop       = out_ready && (cnt_ff != 2'd0);
    // Registered so that the ready output leaves the block straight from a flop
    assign in_ready  = rdy_ff;
    assign out_valid = (cnt_ff != 2'd0);
    assign out_data  = mem_ff[rp_ff];

    always_comb begin
        nxt_wp  = push ? ~wp_ff : wp_ff;
        nxt_rp  = pop ? ~rp_ff : rp_ff;
        nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
        nxt_rdy = (nxt_cnt != 2'd2);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff     <= 1'b0;
            rp_ff     <= 1'b0;
            cnt_ff    <= 2'd0;
            rdy_ff    <= 1'b1;
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
            if (push) begin
                mem_ff[wp_ff] <= in_data;
            end
        end
    end
endmodule
`default_nettype wire

// *** dcc_ctrl.sv ***
// Debug configuration low half: control bits, halt/step logic and trace serialiser
// Overview of operation
// - Trace exception enters emulator mode when trace-emulator bit set, else supervisor.
// - Operand capture field zero shows no operands; 01 writes, 1x reads.
// - Operand sent after size marker, 8/16/32 bits, one nibble per trace clock.
// - Halt instruction is illegal unless background debug enable is set.
// - User-halt permit clear: supervisor only; set: supervisor and user may halt.
// - Branch target trace: 00 none, 01 low two bytes, 1x low three.
// - Non-pipelined bit forces one instruction at a time, no overlap.
// - PC breakpoint always reported before triggering instruction executes.
// - Non-pipelined: address/data breakpoints reported before next instruction begins.
// - In single step, interrupt-ignore bit masks pending interrupts.
// - Single step halts after each instruction; each go runs exactly one.
// - While halted in single step, any debug port command is accepted.
// - Force bit asserts debug-mode output regardless of core state.
// - Debug-mode output follows halt unless halt-disable bit set.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defs.svh"
module dcc_ctrl
    import dcc_pkg::*;
(
    input  wire logic         mclk,              // System clock, 50 MHz
    input  wire logic         rst_n,             // Async reset, active low
    input  wire logic         cfg_wr,            // Debug port write strobe
    input  wire logic [31:0]  cfg_wdata,         // Debug port write data
    input  wire logic         cfg_rd,            // Debug port read strobe
    output var  logic [31:0]  cfg_rdata,         // Lower half read data
    output var  logic         cmd_accept,        // Debug command accepted
    input  wire logic         cmd_valid,         // Debug command pending
    input  wire logic         background_debug_enable, // From extended status
    input  wire logic         go_cmd,            // Debug go command pulse
    input  wire logic         halt_req,          // Halt from breakpoint/halt op
    input  wire logic         insn_start_req,    // Core wants to issue instruction
    input  wire logic         insn_done,         // Core retired an instruction
    input  wire logic         halt_opcode,       // Decoding a halt instruction
    input  wire logic         user_mode,         // Core in user privilege
    input  wire logic         trace_exc,         // Trace exception taken
    input  wire logic         irq_pending,       // Interrupt pending
    input  wire logic         pc_bkpt,           // PC breakpoint hit
    input  wire logic         ad_bkpt,           // Address/data breakpoint hit
    input  wire dcc_operand_t operand,           // Peripheral bus operand
    input  wire logic         branch_taken,      // Taken branch pulse
    input  wire logic [23:0]  branch_target,     // Branch target address
    input  wire logic         trace_output_clock_en, // One pulse per trace clock
    output var  logic         insn_issue_ok,     // Core may issue next instruction
    output var  logic         halt_illegal,      // Treat halt as illegal opcode
    output var  logic         halt_allowed,      // Halt may execute
    output var  logic         emulator_entry,    // Trace exc enters emulator mode
    output var  logic         supervisor_entry,  // Trace exc enters supervisor mode
    output var  logic         irq_take,          // Interrupt may be serviced
    output var  logic         bkpt_report,       // Breakpoint reported to core
    output var  logic         halted,            // Core halted
    output var  logic         debug_mode,        // Debug-mode output to device
    output var  logic         trace_ready,       // Trace path can take a word
    output var  logic [3:0]   trace_data_output  // Trace nibble
);
    import dcc_pkg::*;

    // ****************************************
    // Configuration register
    // ****************************************
    logic [31:0] cfg_ff, nxt_cfg;
    logic        trace_emulator_entry, user_halt_permit, non_pipelined_select, step_interrupt_ignore, single_step_enable, force_debug_output, halt_debug_output_disable;
    logic [1:0]  ddc, branch_target_trace_size;

    always_comb begin
        nxt_cfg = cfg_ff;
        if (cfg_wr) begin
            nxt_cfg = cfg_wdata & `DCC_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= `DCC_RESET;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign trace_emulator_entry = cfg_ff[`DCC_BIT_TRC];
    assign ddc = cfg_ff[`DCC_BIT_DDC_HI:`DCC_BIT_DDC_LO];
    assign user_halt_permit = cfg_ff[`DCC_BIT_UHE];
    assign branch_target_trace_size = cfg_ff[`DCC_BIT_BTB_HI:`DCC_BIT_BTB_LO];
    assign non_pipelined_select = cfg_ff[`DCC_BIT_NPL];
    assign step_interrupt_ignore = cfg_ff[`DCC_BIT_IPI];
    assign single_step_enable = cfg_ff[`DCC_BIT_SSM];
    assign force_debug_output = cfg_ff[`DCC_BIT_FID];
    assign halt_debug_output_disable = cfg_ff[`DCC_BIT_DDH];

    // ****************************************
    // Run control: halt, single step, pipeline
    // ****************************************
    typedef enum logic [1:0] {ST_RUN, ST_STEP, ST_HALT} dcc_run_t;
    dcc_run_t run_ff, nxt_run;
    logic     busy_ff, nxt_busy;
    logic     bkpt_pend_ff, nxt_bkpt_pend;

    always_comb begin
        nxt_run       = run_ff;
        nxt_busy      = busy_ff;
        nxt_bkpt_pend = bkpt_pend_ff;
        // Non-pipelined: one instruction in flight at most
        if (insn_start_req && (run_ff != ST_HALT) && !(non_pipelined_select && busy_ff)) begin
            nxt_busy = 1'b1;
        end
        if (insn_done) begin
            nxt_busy = 1'b0;
        end
        if (ad_bkpt) begin
            nxt_bkpt_pend = 1'b1;
        end else if (bkpt_pend_ff && !busy_ff) begin
            nxt_bkpt_pend = 1'b0;
        end
        unique case (run_ff)
            ST_RUN: begin
                if (halt_req || pc_bkpt) begin
                    nxt_run = ST_HALT;
                end else if (single_step_enable && insn_done) begin
                    nxt_run = ST_HALT;
                end
            end
            ST_STEP: begin
                // A stepped instruction that hits a PC breakpoint must not run
                if (insn_done || halt_req || pc_bkpt) begin
                    nxt_run = ST_HALT;
                end
            end
            ST_HALT: begin
                if (go_cmd) begin
                    nxt_run = single_step_enable ? ST_STEP : ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff       <= ST_RUN;
            busy_ff      <= 1'b0;
            bkpt_pend_ff <= 1'b0;
        end else begin
            run_ff       <= nxt_run;
            busy_ff      <= nxt_busy;
            bkpt_pend_ff <= nxt_bkpt_pend;
        end
    end

    // ****************************************
    // Registered core-facing outputs
    // ****************************************
    logic step_once_ff, nxt_step_once;
    logic issue_ok_ff, nxt_issue_ok;
    logic illegal_ff, nxt_illegal, allow_ff, nxt_allow;
    logic emu_ff, nxt_emu, sup_ff, nxt_sup, irq_ff, nxt_irq;
    logic rep_ff, nxt_rep, halted_ff, nxt_halted, dbg_ff, nxt_dbg, acc_ff, nxt_acc;
    logic [31:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_step_once = step_once_ff;
        if (go_cmd) begin
            nxt_step_once = 1'b1;
        end else if (insn_start_req && issue_ok_ff) begin
            nxt_step_once = 1'b0;
        end
        // Step issues only the single instruction granted by go
        nxt_issue_ok = (nxt_run == ST_RUN) || (nxt_run == ST_STEP && nxt_step_once);
        nxt_issue_ok = nxt_issue_ok && !pc_bkpt && !(non_pipelined_select && nxt_busy);
        nxt_illegal  = halt_opcode && !background_debug_enable;
        nxt_allow    = halt_opcode && background_debug_enable && (user_halt_permit || !user_mode);
        nxt_emu      = trace_exc && trace_emulator_entry;
        nxt_sup      = trace_exc && !trace_emulator_entry;
        nxt_irq      = irq_pending && !(single_step_enable && step_interrupt_ignore) && (nxt_run != ST_HALT);
        // PC breakpoints always precede execution; a/d only precise when serialised
        nxt_rep      = pc_bkpt || (non_pipelined_select ? (ad_bkpt || bkpt_pend_ff) : ad_bkpt);
        nxt_halted   = (nxt_run == ST_HALT);
        nxt_dbg      = force_debug_output || (nxt_halted && !halt_debug_output_disable);
        nxt_acc      = cmd_valid && ((run_ff == ST_HALT) || !single_step_enable);
        nxt_rdata    = cfg_rd ? (cfg_ff & `DCC_WMASK) : rdata_ff;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_once_ff <= 1'b0;
            issue_ok_ff  <= 1'b0;
            illegal_ff   <= 1'b0;
            allow_ff     <= 1'b0;
            emu_ff       <= 1'b0;
            sup_ff       <= 1'b0;
            irq_ff       <= 1'b0;
            rep_ff       <= 1'b0;
            halted_ff    <= 1'b0;
            dbg_ff       <= 1'b0;
            acc_ff       <= 1'b0;
            rdata_ff     <= 32'h0000_0000;
        end else begin
            step_once_ff <= nxt_step_once;
            issue_ok_ff  <= nxt_issue_ok;
            illegal_ff   <= nxt_illegal;
            allow_ff     <= nxt_allow;
            emu_ff       <= nxt_emu;
            sup_ff       <= nxt_sup;
            irq_ff       <= nxt_irq;
            rep_ff       <= nxt_rep;
            halted_ff    <= nxt_halted;
            dbg_ff       <= nxt_dbg;
            acc_ff       <= nxt_acc;
            rdata_ff     <= nxt_rdata;
        end
    end

    assign insn_issue_ok    = issue_ok_ff;
    assign halt_illegal     = illegal_ff;
    assign halt_allowed     = allow_ff;
    assign emulator_entry   = emu_ff;
    assign supervisor_entry = sup_ff;
    assign irq_take         = irq_ff;
    assign bkpt_report      = rep_ff;
    assign halted           = halted_ff;
    assign debug_mode       = dbg_ff;
    assign cmd_accept       = acc_ff;
    assign cfg_rdata        = rdata_ff;

    // ****************************************
    // Trace capture and nibble serialiser
    // ****************************************
    function automatic dcc_trace_t op_word(input dcc_operand_t op);
        op_word.data = op.data;
        unique case (op.size)
            DCC_SZ_BYTE: begin
                op_word.mark    = `DCC_MARK_BYTE;
                op_word.nibbles = `DCC_BYTE_NIBBLES;
            end
            DCC_SZ_WORD: begin
                op_word.mark    = `DCC_MARK_WORD;
                op_word.nibbles = `DCC_WORD_NIBBLES;
            end
            default: begin
                op_word.mark    = `DCC_MARK_LONG;
                op_word.nibbles = `DCC_LONG_NIBBLES;
            end
        endcase
    endfunction

    dcc_trace_t cap_word, buf_word;
    logic       cap_valid, buf_valid, buf_pop;
    logic       op_hit, br_hit;

    // Operand capture wins a same-cycle collision; branch target then dropped
    assign op_hit = operand.valid && ((ddc == 2'b01 && operand.is_write)
                    || (ddc[1] && !operand.is_write));
    assign br_hit = branch_taken && (branch_target_trace_size != 2'b00);

    always_comb begin
        cap_word  = '0;
        cap_valid = op_hit || br_hit;
        if (op_hit) begin
            cap_word = op_word(operand);
        end else if (br_hit) begin
            cap_word.data    = {8'h00, branch_target};
            cap_word.mark    = branch_target_trace_size[1] ? `DCC_MARK_BTB3 : `DCC_MARK_BTB2;
            cap_word.nibbles = branch_target_trace_size[1] ? `DCC_BTB3_NIBBLES : `DCC_BTB2_NIBBLES;
        end
    end

    dcc_buf2 u_buf (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_data   (cap_word),
        .in_valid  (cap_valid),
        .in_ready  (trace_ready),
        .out_data  (buf_word),
        .out_valid (buf_valid),
        .out_ready (buf_pop)
    );

    logic [31:0] sh_ff, nxt_sh;
    logic [3:0]  left_ff, nxt_left, nib_ff, nxt_nib;
    logic        act_ff, nxt_act;

    assign buf_pop = !act_ff && buf_valid && trace_output_clock_en;

    always_comb begin
        nxt_sh   = sh_ff;
        nxt_left = left_ff;
        nxt_nib  = nib_ff;
        nxt_act  = act_ff;
        if (trace_output_clock_en) begin
            if (act_ff) begin
                // Low nibble first, one per trace clock
                nxt_nib  = sh_ff[3:0];
                nxt_sh   = {4'h0, sh_ff[31:4]};
                nxt_left = left_ff - 4'h1;
                nxt_act  = (left_ff != 4'h1);
            end else if (buf_valid) begin
                nxt_nib  = buf_word.mark;
                nxt_sh   = buf_word.data;
                nxt_left = buf_word.nibbles;
                nxt_act  = 1'b1;
            end else begin
                nxt_nib = 4'h0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sh_ff   <= 32'h0000_0000;
            left_ff <= 4'h0;
            nib_ff  <= 4'h0;
            act_ff  <= 1'b0;
        end else begin
            sh_ff   <= nxt_sh;
            left_ff <= nxt_left;
            nib_ff  <= nxt_nib;
            act_ff  <= nxt_act;
        end
    end

    assign trace_data_output = nib_ff;
endmodule
`default_nettype wire

// *** dcc_ctrl_checker.sv ***
// Port checks for the debug configuration control block
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defs.svh"
module dcc_ctrl_checker (
    input wire logic        mclk,         // Clock
    input wire logic        rst_n,        // Reset
    input wire logic        cfg_wr,       // Write
    input wire logic [31:0] cfg_wdata,    // Write data
    input wire logic        cfg_rd,       // Read
    input wire logic [31:0] cfg_rdata,    // Read data
    input wire logic        cmd_valid,    // Command
    input wire logic        cmd_accept,   // Accepted
    input wire logic        background_debug_enable, // Enable
    input wire logic        halt_opcode,  // Halt op
    input wire logic        user_mode,    // User
    input wire logic        halt_illegal, // Illegal
    input wire logic        halt_allowed, // Allowed
    input wire logic        irq_pending,  // Irq
    input wire logic        irq_take,     // Serviced
    input wire logic        pc_bkpt,      // PC hit
    input wire logic        insn_done,    // Retired
    input wire logic        halted,       // Halted
    input wire logic        debug_mode    // Debug out
);
    // ********
    // Shadow of the writable bits
    // ********
    logic [31:0] sh_ff;
    logic [31:0] nxt_sh;
    always_comb nxt_sh = cfg_wr ? (cfg_wdata & `DCC_WMASK) : sh_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) sh_ff <= 32'h0000_0000;
        else sh_ff <= nxt_sh;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    rd_back_a: assert property (cfg_rd && !cfg_wr |=> cfg_rdata == $past(sh_ff))
        else $error("read data differs from written bits");
    resv_zero_a: assert property ((cfg_rdata & ~`DCC_WMASK) == 32'h0000_0000)
        else $error("reserved bit read nonzero");
    halt_ill_a: assert property (halt_opcode |=> halt_illegal == !$past(background_debug_enable))
        else $error("halt legality wrong");
    halt_priv_a: assert property (halt_opcode && background_debug_enable && user_mode
        |=> halt_allowed == $past(sh_ff[10])) else $error("user halt permission wrong");
    irq_mask_a: assert property (irq_pending && sh_ff[4] && sh_ff[5] |=> !irq_take)
        else $error("interrupt taken in masked step");
    pc_halt_a: assert property (pc_bkpt && !halted |=> halted)
        else $error("pc breakpoint did not halt");
    step_halt_a: assert property (insn_done && sh_ff[4] && !halted |=> halted)
        else $error("no halt after stepped instruction");
    cmd_take_a: assert property (cmd_valid && halted |=> cmd_accept)
        else $error("command refused while halted");
    force_dbg_a: assert property (sh_ff[1] && $past(sh_ff[1]) |-> debug_mode)
        else $error("forced debug output low");
    halt_dbg_a: assert property (halted && $past(halted) && !sh_ff[0] && !$past(sh_ff[0])
        && !sh_ff[1] |-> debug_mode) else $error("halt did not raise debug output");
    cover property (halted && cmd_valid);
    cover property (insn_done && sh_ff[4]);
    cover property (sh_ff[0] && halted);
endmodule
`default_nettype wire

// *** dcc_sink.sv ***
// Trace consumer model: makes trace clock enables and records nibbles
`timescale 1ns/1ps
`default_nettype none
module dcc_sink (
    input  wire logic       mclk, // Clock
    input  wire logic       run,  // Trace clock running
    input  wire logic [3:0] nib,  // Trace nibble
    output var  logic       en    // Trace clock enable
);
    // ********
    // Capture, one nibble per trace clock
    // ********
    logic [3:0] q [$];
    logic       en_d;
    initial begin
        en = 1'b0;
        en_d = 1'b0;
    end
    // Stopping run stalls the block, which must then hold its words
    always @(posedge mclk) begin
        if (en_d) q.push_back(nib);
        en_d <= en;
        en <= run & !en;
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the debug configuration control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcc_pkg::*;
    logic mclk, rst_n, cfg_wr, cfg_rd, cmd_valid, go_cmd, halt_req, run;
    logic background_debug_enable, insn_start_req, insn_done, halt_opcode;
    logic user_mode, trace_exc, irq_pending, pc_bkpt, ad_bkpt, branch_taken;
    logic trace_output_clock_en, cmd_accept, insn_issue_ok, halt_illegal;
    logic halt_allowed, emulator_entry, supervisor_entry, irq_take;
    logic bkpt_report, halted, debug_mode, trace_ready;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [23:0] branch_target;
    logic [3:0]  trace_data_output;
    dcc_operand_t operand;
    int n_errors, total_checks;
    dcc_ctrl u_dcc_ctrl (.*);
    dcc_sink u_dcc_sink (.mclk(mclk), .run(run), .nib(trace_data_output), .en(trace_output_clock_en));
    // ********
    // Shared tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pl(ref logic s);
        @(negedge mclk) s = 1'b1;
        @(negedge mclk) s = 1'b0;
    endtask
    task automatic wr(input logic [31:0] d);
        cfg_wdata = d;
        pl(cfg_wr);
    endtask
    task automatic op(input logic w, input dcc_size_t sz, input logic [31:0] d);
        operand = '{1'b1, w, sz, d};
        @(negedge mclk) operand.valid = 1'b0;
        @(negedge mclk);
    endtask
    task automatic tr_chk(input string nm, input logic [3:0] mk, input logic [31:0] d, input int n);
        int k;
        k = 0;
        repeat (40) @(negedge mclk);
        while (k < u_dcc_sink.q.size() && u_dcc_sink.q[k] === 4'h0) k++;
        chk(nm, mk, (k < u_dcc_sink.q.size()) ? u_dcc_sink.q[k] : 4'h0);
        for (int j = 0; j < n; j++) chk(nm, d[4*j+:4], u_dcc_sink.q[k+1+j]);
        u_dcc_sink.q.delete();
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reg;
        pl(cfg_rd);
        chk("reset value", 32'h0000_0000, cfg_rdata);
        wr(32'hFFFF_FFFF);
        pl(cfg_rd);
        chk("reserved bits", 32'h0000_5F73, cfg_rdata);
    endtask
    task automatic t_entry;
        for (int i = 0; i < 2; i++) begin
            wr(i ? 32'h0000_4000 : 32'h0000_0000);
            pl(trace_exc);
            chk("emulator entry", i, emulator_entry);
            chk("supervisor entry", !i, supervisor_entry);
        end
    endtask
    task automatic t_halt_op;
        for (int i = 0; i < 8; i++) begin
            wr({21'h0, i[2], 10'h0});
            background_debug_enable = i[0];
            user_mode = i[1];
            pl(halt_opcode);
            chk("halt illegal", !i[0], halt_illegal);
            chk("halt allowed", i[0] & (!i[1] | i[2]), halt_allowed);
        end
    endtask
    task automatic t_step;
        int seen;
        wr(32'h0000_0030);
        pl(halt_req);
        chk("halted", 1, halted);
        cmd_valid = 1'b1;
        @(negedge mclk) cmd_valid = 1'b0;
        chk("accept", 1, cmd_accept);
        chk("debug out", 1, debug_mode);
        for (int g = 0; g < 2; g++) begin
            seen = 0;
            pl(go_cmd);
            chk("running", 0, halted);
            chk("issue", 1, insn_issue_ok);
            irq_pending = 1'b1;
            @(negedge mclk) irq_pending = 1'b0;
            chk("irq ignored", 0, irq_take);
            repeat (3) @(negedge mclk) seen += insn_issue_ok;
            chk("no second issue", 0, seen);
            pl(insn_done);
            chk("halt again", 1, halted);
        end
        wr(32'h0000_0031);
        repeat (2) @(negedge mclk);
        chk("halt output off", 0, debug_mode);
        wr(32'h0000_0033);
        repeat (2) @(negedge mclk);
        chk("forced output", 1, debug_mode);
        wr(32'h0000_0000);
        pl(go_cmd);
        irq_pending = 1'b1;
        @(negedge mclk) irq_pending = 1'b0;
        chk("irq served", 1, irq_take);
    endtask
    task automatic t_bkpt;
        wr(32'h0000_0040);
        pl(pc_bkpt);
        chk("pc halt", 1, halted);
        pl(go_cmd);
        chk("serialised", 0, insn_issue_ok);
        pl(insn_done);
        chk("issue after done", 1, insn_issue_ok);
        pl(ad_bkpt);
        chk("precise report", 1, bkpt_report);
        pl(go_cmd);
    endtask
    task automatic t_trace;
        run = 1'b1;
        wr(32'h0000_0800);
        for (int s = 0; s < 3; s++) begin
            op(1'b1, dcc_size_t'(s), 32'h8765_4321);
            tr_chk("write operand", s == 0 ? 4'h8 : s == 1 ? 4'h9 : 4'hB, 32'h8765_4321, 2 << s);
        end
        wr(32'h0000_1000);
        op(1'b1, DCC_SZ_LONG, 32'h8765_4321);
        tr_chk("write skipped", 4'h0, 32'h0, 0);
        op(1'b0, DCC_SZ_WORD, 32'h0000_CAFE);
        tr_chk("read operand", 4'h9, 32'h0000_CAFE, 4);
        for (int b = 0; b < 3; b++) begin
            wr({22'h0, b[1:0], 8'h0});
            branch_target = 24'hABCD_EF;
            pl(branch_taken);
            tr_chk("branch target", b == 0 ? 4'h0 : b == 1 ? 4'hA : 4'hC, 32'h00AB_CDEF, b == 0 ? 0 : 2 + 2 * b);
        end
    endtask
    task automatic t_fill;
        int p;
        int c;
        p = 0;
        c = 0;
        run = 1'b0;
        wr(32'h0000_0800);
        while (trace_ready === 1'b1 && p < 6) begin
            op(1'b1, DCC_SZ_LONG, 32'h1111_1111);
            p++;
        end
        chk("buffer refuses", 0, trace_ready);
        run = 1'b1;
        repeat (150) @(negedge mclk);
        foreach (u_dcc_sink.q[i]) c += (u_dcc_sink.q[i] === 4'hB);
        chk("words kept", p, c);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        {rst_n, cfg_wr, cfg_rd, cmd_valid, go_cmd, halt_req, run, trace_exc} = '0;
        {background_debug_enable, insn_done, halt_opcode, user_mode} = '0;
        {irq_pending, pc_bkpt, ad_bkpt, branch_taken} = '0;
        insn_start_req = 1'b1;
        cfg_wdata = '0;
        branch_target = '0;
        operand = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        t_reg();
        t_entry();
        t_halt_op();
        t_step();
        t_bkpt();
        t_trace();
        t_fill();
        close_out();
    end
    // Whole run needs under 2000 cycles
    initial begin
        repeat (6000) @(posedge mclk);
        n_errors++;
        close_out();
    end
endmodule
bind dcc_ctrl dcc_ctrl_checker u_dcc_ctrl_checker (.*);
`default_nettype wire
